// >>> include/fxu_map.svh
// Register offsets, field positions, reset values for the exception unit
`ifndef FXU_MAP_SVH
`define FXU_MAP_SVH
`define FXU_ADDR_CTRL     12'h000
`define FXU_ADDR_STATUS   12'h004
`define FXU_ADDR_OP       12'h008
`define FXU_ADDR_RESULT   12'h00C
`define FXU_ADDR_IPTR     12'h010
`define FXU_ADDR_DPTR     12'h014
`define FXU_ADDR_CMD      12'h018
`define FXU_CTRL_RST      16'h0000
`define FXU_CTRL_INIT     16'h037F
`define FXU_CTRL_RSV_BIT  12
`define FXU_RC_LO         10
`define FXU_ES_BIT        7
`define FXU_SF_BIT        6
`define FXU_STAT_RST      16'h0081
`define FXU_STAT_INIT     16'h0000
`define FXU_CC_MASK       16'h4700
`define FXU_CMD_INIT      0
`define FXU_CMD_PREM_INC  1
`define FXU_CMD_CLEX      2
`endif

// >>> include/fxu_pkg.sv
// Types for the floating-point exception unit
package fxu_pkg;
  typedef enum logic [2:0] {
    FXU_OP_ARITH,
    FXU_OP_LOAD_SD,
    FXU_OP_LOAD_EXT,
    FXU_OP_CMP_STORE,
    FXU_OP_EXTRACT,
    FXU_OP_TAN,
    FXU_OP_SCALE
  } fxu_op_e;
  typedef enum logic [2:0] {
    FXU_RES_NORMAL,
    FXU_RES_QNAN,
    FXU_RES_INF,
    FXU_RES_MAXFIN,
    FXU_RES_DENZERO,
    FXU_RES_ZERO,
    FXU_RES_NEGINF_ST1
  } fxu_res_e;
endpackage

// >>> rtl/fxu_exc.sv
// Floating-point exception detection, flags, error output and pin tristate
// Functional notes
// - Six exceptions ranked invalid, denormal, zero-divide, overflow, underflow, inexact.
// - Control bits 5..0 mask the six exceptions; set means default response.
// - Unmasked exception sets its flag, summary bit and asserts error low.
// - Any exception saves instruction address, and operand address when it has a memory operand.
// - After reset error asserted: invalid flag, summary set, invalid mask clear.
// - No-wait initialize clears error and sets defined control and status values.
// - Control bit 12 reserved, cleared by reset or init, writable.
// - Condition codes cleared on reset, init and incomplete partial remainder.
// - Masked invalid gives quiet NaN; stack fault also sets stack-fault flag.
// - Masked zero-divide with finite nonzero dividend returns infinity.
// - Masked overflow returns largest finite or infinity per rounding mode.
// - Masked underflow flagged only when denormalizing loses accuracy.
// - Masked denormal operand is normalized and processing continues.
// - Inexact result signals inexact and rounds; masked continues.
// - Extract of zero reports zero-divide, leaves minus infinity in second register.
// - Only signaling NaNs raise, except compare and stores raise for quiet NaNs.
// - Single/double load of denormal signals denormal; sNaN invalid; extended never denormal.
// - Partial tangent stack overflow, overflow masked: both registers get quiet NaNs.
// - Scale by infinity: zero invalid, minus gives signed zero, plus signed infinity.
// - Partial tangent puts tangent in second register, one in top.
// - Error and data pin outputs float unless status enable active.
// - Data pins drive only in selected read cycles with status enable.
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`include "fxu_map.svh"
`timescale 1ns/1ps
`default_nettype none
module fxu_exc
  import fxu_pkg::*;
(
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Operation report from the datapath
  input  wire logic        op_valid,
  input  wire fxu_pkg::fxu_op_e op_kind,
  input  wire logic [5:0]  op_cond,
  input  wire logic        op_stack_fault,
  input  wire logic        op_snan,
  input  wire logic        op_qnan,
  input  wire logic        op_zero_src,
  input  wire logic        op_scale_neg,
  input  wire logic        op_has_mem,
  input  wire logic [31:0] op_iaddr,
  input  wire logic [31:0] op_daddr,
  // Pin side
  input  wire logic        status_enable,
  input  wire logic        coproc_select_low_n,
  input  wire logic        coproc_select_high,
  input  wire logic        bus_read,
  input  wire logic [31:0] bus_rdata,
  output logic             error_n_out,
  output logic             error_n_oe_n,
  output logic      [31:0] data_out,
  output logic             data_oe_n,
  // Result action toward the datapath
  output fxu_pkg::fxu_res_e res_action,
  output logic             res_sign_keep,
  output logic             res_normalize
);
  import fxu_pkg::*;

  localparam int NEXC = 6;

  logic [15:0] control_word, next_control_word;
  logic [15:0] status_word,  next_status_word;
  logic [31:0] iptr, next_iptr, dptr, next_dptr;
  fxu_res_e    next_res_action;
  logic        next_res_sign_keep, next_res_normalize;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        next_error_n_out, next_error_n_oe_n, next_data_oe_n;
  logic [31:0] next_data_out;
  logic [5:0]  raw;
  logic [5:0]  unmasked;
  logic [2:0]  top_idx;

  // Bit mask of the highest-ranked set bit, invalid at bit 0
  function automatic logic [5:0] prio_pick(input logic [5:0] v);
    logic [5:0] r;
    r = 6'h00;
    for (int i = NEXC - 1; i >= 0; i--)
    begin
      if (v[i])
        r = 6'h01 << i;
    end
    return r;
  endfunction

  wire acc   = psel && penable;
  // Write lands only at the completing edge, once
  wire wr_ok = acc && pwrite && pready;

  // Exception conditions after instruction-specific adjustment
  always_comb
  begin
    raw = op_valid ? op_cond : 6'h00;
    if (op_valid && op_stack_fault)
      raw[0] = 1'b1;
    if (op_valid && (op_snan || (op_qnan && op_kind == FXU_OP_CMP_STORE)))
      raw[0] = 1'b1;
    if (op_valid && op_kind == FXU_OP_LOAD_EXT)
      raw[1] = 1'b0;
    if (op_valid && op_kind == FXU_OP_EXTRACT && op_zero_src)
      raw[2] = 1'b1;
    if (op_valid && op_kind == FXU_OP_SCALE && op_zero_src)
      raw[0] = 1'b1;
    unmasked = raw & ~control_word[5:0];
    top_idx  = 3'd0;
    for (int i = NEXC - 1; i >= 0; i--)
    begin
      if (prio_pick(raw) == (6'h01 << i))
        top_idx = 3'(i);
    end
  end

  // Masked default responses, highest precedence first
  always_comb
  begin
    next_res_action    = FXU_RES_NORMAL;
    next_res_sign_keep = 1'b0;
    next_res_normalize = 1'b0;
    if (op_valid)
    begin
      if (op_kind == FXU_OP_TAN && op_stack_fault && control_word[3])
        next_res_action = FXU_RES_QNAN;
      else if (raw != 6'h00)
      begin
        case (top_idx)
          3'd0: next_res_action = FXU_RES_QNAN;
          3'd1: next_res_normalize = 1'b1;
          3'd2: next_res_action = (op_kind == FXU_OP_EXTRACT) ? FXU_RES_NEGINF_ST1 : FXU_RES_INF;
          3'd3: next_res_action = (control_word[11:10] == 2'b11 || control_word[11:10] == 2'b01) ?
                                  FXU_RES_MAXFIN : FXU_RES_INF;
          3'd4: next_res_action = FXU_RES_DENZERO;
          default: next_res_action = FXU_RES_NORMAL;
        endcase
      end
      else if (op_kind == FXU_OP_SCALE)
      begin
        next_res_action    = op_scale_neg ? FXU_RES_ZERO : FXU_RES_INF;
        next_res_sign_keep = 1'b1;
      end
      // Tangent: true tangent in second, one in top unless faulted
      else if (op_kind == FXU_OP_TAN)
        next_res_action = FXU_RES_NORMAL;
    end
  end

  // Control, status and pointers
  always_comb
  begin
    next_control_word = control_word;
    next_status_word  = status_word;
    next_iptr         = iptr;
    next_dptr         = dptr;
    if (wr_ok && paddr == `FXU_ADDR_CTRL && pstrb[0])
      next_control_word[7:0] = pwdata[7:0];
    if (wr_ok && paddr == `FXU_ADDR_CTRL && pstrb[1])
      next_control_word[15:8] = pwdata[15:8];
    if (wr_ok && paddr == `FXU_ADDR_CMD && pwdata[`FXU_CMD_CLEX])
      next_status_word = status_word & ~16'h00FF;
    if (wr_ok && paddr == `FXU_ADDR_CMD && pwdata[`FXU_CMD_PREM_INC])
      next_status_word = next_status_word & ~`FXU_CC_MASK;
    if (wr_ok && paddr == `FXU_ADDR_CMD && pwdata[`FXU_CMD_INIT])
    begin
      next_control_word = `FXU_CTRL_INIT;
      next_status_word  = `FXU_STAT_INIT;
    end
    // Set wins over a same-cycle clear
    if (op_valid && raw != 6'h00)
    begin
      next_iptr = op_iaddr;
      if (op_has_mem)
        next_dptr = op_daddr;
    end
    if (unmasked != 6'h00)
    begin
      next_status_word[5:0]        = next_status_word[5:0] | unmasked;
      next_status_word[`FXU_ES_BIT] = 1'b1;
    end
    next_status_word[5:0] = next_status_word[5:0] | raw;
    if (op_valid && op_stack_fault)
      next_status_word[`FXU_SF_BIT] = 1'b1;
  end

  // APB slave, one wait state
  always_comb
  begin
    next_pready  = acc && !pready;
    next_pslverr = 1'b0;
    next_prdata  = 32'h0000_0000;
    if (acc && !pready && !pwrite)
    begin
      if (paddr == `FXU_ADDR_CTRL)
        next_prdata = {16'h0000, control_word};
      else if (paddr == `FXU_ADDR_STATUS)
        next_prdata = {16'h0000, status_word};
      else if (paddr == `FXU_ADDR_RESULT)
        next_prdata = {25'h000_0000, res_normalize, res_sign_keep, 2'b00, res_action};
      else if (paddr == `FXU_ADDR_IPTR)
        next_prdata = iptr;
      else if (paddr == `FXU_ADDR_DPTR)
        next_prdata = dptr;
      else if (paddr != `FXU_ADDR_CMD && paddr != `FXU_ADDR_OP)
        next_pslverr = 1'b1;
    end
  end

  // Pins
  always_comb
  begin
    next_error_n_out  = ~next_status_word[`FXU_ES_BIT];
    next_error_n_oe_n = ~status_enable;
    next_data_oe_n    = ~(status_enable && !coproc_select_low_n
                          && coproc_select_high && bus_read);
    next_data_out     = bus_rdata;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      control_word  <= `FXU_CTRL_RST;
      status_word   <= `FXU_STAT_RST;
      iptr          <= 32'h0000_0000;
      dptr          <= 32'h0000_0000;
      res_action    <= FXU_RES_NORMAL;
      res_sign_keep <= 1'b0;
      res_normalize <= 1'b0;
      prdata        <= 32'h0000_0000;
      pready        <= 1'b0;
      pslverr       <= 1'b0;
      error_n_out   <= 1'b0;
      error_n_oe_n  <= 1'b1;
      data_out      <= 32'h0000_0000;
      data_oe_n     <= 1'b1;
    end
    else
    begin
      control_word  <= next_control_word;
      status_word   <= next_status_word;
      iptr          <= next_iptr;
      dptr          <= next_dptr;
      res_action    <= next_res_action;
      res_sign_keep <= next_res_sign_keep;
      res_normalize <= next_res_normalize;
      prdata        <= next_prdata;
      pready        <= next_pready;
      pslverr       <= next_pslverr;
      error_n_out   <= next_error_n_out;
      error_n_oe_n  <= next_error_n_oe_n;
      data_out      <= next_data_out;
      data_oe_n     <= next_data_oe_n;
    end
  end

  // Checks
  property p_error_follows_summary;
    @(posedge pclk) disable iff (!presetn)
    ##1 (error_n_out == ~status_word[`FXU_ES_BIT]);
  endproperty
  a_error_follows_summary: assert property (p_error_follows_summary)
    else $error("error output disagrees with summary bit");

  property p_unmasked_sets;
    @(posedge pclk) disable iff (!presetn)
    (unmasked != 6'h00) |=> (status_word[`FXU_ES_BIT] && !error_n_out ##0 ((status_word[5:0] & $past(unmasked)) == $past(unmasked)));
  endproperty
  a_unmasked_sets: assert property (p_unmasked_sets)
    else $error("unmasked exception did not set flag and summary");

  property p_masked_no_summary;
    @(posedge pclk) disable iff (!presetn)
    (op_valid && unmasked == 6'h00 && !status_word[`FXU_ES_BIT] && !(wr_ok)) |=> !status_word[`FXU_ES_BIT];
  endproperty
  a_masked_no_summary: assert property (p_masked_no_summary)
    else $error("masked exception set the summary bit");

  property p_init_clears;
    @(posedge pclk) disable iff (!presetn)
    (wr_ok && paddr == `FXU_ADDR_CMD && pwdata[`FXU_CMD_INIT] && unmasked == 6'h00)
      |=> (control_word == `FXU_CTRL_INIT && (status_word & `FXU_CC_MASK) == 16'h0000) ##1 error_n_out;
  endproperty
  a_init_clears: assert property (p_init_clears)
    else $error("initialize did not clear error and words");

  property p_data_float;
    @(posedge pclk) disable iff (!presetn)
    !status_enable |=> data_oe_n && error_n_oe_n;
  endproperty
  a_data_float: assert property (p_data_float)
    else $error("outputs driven without status enable");

  property p_data_drive;
    @(posedge pclk) disable iff (!presetn)
    (status_enable && !coproc_select_low_n && coproc_select_high && bus_read) |=> !data_oe_n;
  endproperty
  a_data_drive: assert property (p_data_drive)
    else $error("data pins not driven in selected read");

  property p_pointer_saved;
    @(posedge pclk) disable iff (!presetn)
    (op_valid && raw != 6'h00) |=> (iptr == $past(op_iaddr));
  endproperty
  a_pointer_saved: assert property (p_pointer_saved)
    else $error("instruction address not saved");

  property p_stack_fault;
    @(posedge pclk) disable iff (!presetn)
    (op_valid && op_stack_fault && control_word[0]) |=> (status_word[`FXU_SF_BIT] && res_action == FXU_RES_QNAN);
  endproperty
  a_stack_fault: assert property (p_stack_fault)
    else $error("stack fault response wrong");

  property p_ext_no_denormal;
    @(posedge pclk) disable iff (!presetn)
    (op_valid && op_kind == FXU_OP_LOAD_EXT) |-> !raw[1];
  endproperty
  a_ext_no_denormal: assert property (p_ext_no_denormal)
    else $error("extended load raised denormal");

  property p_invalid_first;
    @(posedge pclk) disable iff (!presetn)
    (op_valid && raw[0]) |=> (res_action == FXU_RES_QNAN);
  endproperty
  a_invalid_first: assert property (p_invalid_first)
    else $error("invalid operation did not take precedence");

  property p_extract_zero;
    @(posedge pclk) disable iff (!presetn)
    (op_valid && op_kind == FXU_OP_EXTRACT && op_zero_src && raw[1:0] == 2'b00)
      |=> (res_action == FXU_RES_NEGINF_ST1 && status_word[2]);
  endproperty
  a_extract_zero: assert property (p_extract_zero)
    else $error("extract of zero did not report zero-divide");
endmodule
`default_nettype wire

// >>> sim/fxu_host_model.sv
// Host processor model: samples the error pin and takes vector 16 on escape or wait
`timescale 1ns/1ps
`default_nettype none
module fxu_host_model
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Error pin of the coprocessor
  input  wire logic error_n_out,
  input  wire logic error_n_oe_n,
  // Escape or wait issued by host software
  input  wire logic esc_req,
  output logic      trap16
);
  logic error_wire;

  // Floating pin reads high through the pull-up
  assign error_wire = error_n_oe_n ? 1'b1 : error_n_out;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      trap16 <= 1'b0;
    else
      trap16 <= esc_req && !error_wire;
  end
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench for the floating-point exception unit
`include "fxu_map.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fxu_pkg::*;
  localparam logic [11:0] a_ctrl = `FXU_ADDR_CTRL;
  localparam logic [11:0] a_stat = `FXU_ADDR_STATUS;
  localparam logic [11:0] a_cmd  = `FXU_ADDR_CMD;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, op_iaddr, op_daddr, bus_rdata, data_out, rd;
  logic [3:0]  pstrb;
  logic        op_valid, op_stack_fault, op_snan, op_qnan, op_zero_src, op_scale_neg, op_has_mem;
  logic        status_enable, coproc_select_low_n, coproc_select_high, bus_read;
  logic        error_n_out, error_n_oe_n, data_oe_n, res_sign_keep, res_normalize, esc_req, trap16;
  logic [5:0]  op_cond;
  logic [1:0]  rk;
  fxu_op_e     op_kind;
  fxu_res_e    res_action;
  int          miscompares, tests_run;

  fxu_exc u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .op_valid, .op_kind, .op_cond, .op_stack_fault, .op_snan, .op_qnan, .op_zero_src,
    .op_scale_neg, .op_has_mem, .op_iaddr, .op_daddr, .status_enable, .coproc_select_low_n,
    .coproc_select_high, .bus_read, .bus_rdata, .error_n_out, .error_n_oe_n, .data_out, .data_oe_n,
    .res_action, .res_sign_keep, .res_normalize);
  fxu_host_model u_host (.pclk, .presetn, .error_n_out, .error_n_oe_n, .esc_req, .trap16);

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    rerr = pslverr;
    chk(32'(pready), 32'h0000_0001);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  task automatic op(input fxu_op_e k, input logic [5:0] c, input logic [4:0] fl);
    @(posedge pclk);
    op_valid <= 1'b1;
    op_kind <= k;
    op_cond <= c;
    {op_stack_fault, op_snan, op_qnan, op_zero_src, op_scale_neg} <= fl;
    op_iaddr <= op_iaddr + 32'h0000_0100;
    op_daddr <= op_daddr + 32'h0000_0020;
    @(posedge pclk);
    op_valid <= 1'b0;
    @(posedge pclk);
  endtask

  // Masked operation from a clean status; checks action and flags
  task automatic act(input fxu_op_e k, input logic [5:0] c, input logic [4:0] fl,
                     input fxu_res_e ea, input logic [7:0] es);
    apb(1'b1, a_cmd, 32'h0000_0004);
    op(k, c, fl);
    chk(32'(res_action), 32'(ea));
    rk = {res_normalize, res_sign_keep};
    rdchk(a_stat, {24'h00_0000, es});
  endtask

  task automatic coprocessor_escape;
    @(posedge pclk);
    esc_req <= 1'b1;
    @(posedge pclk);
    esc_req <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic t_reset;
    rdchk(a_ctrl, 32'h0000_0000);
    rdchk(a_stat, 32'h0000_0081);
    chk(32'(error_n_out), 32'h0000_0000);
    chk(32'({error_n_oe_n, data_oe_n}), 32'h0000_0003);
    apb(1'b1, a_stat, 32'h0000_0000);
    rdchk(a_stat, 32'h0000_0081);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk(32'(rerr), 32'h0000_0001);
  endtask

  task automatic t_init;
    apb(1'b1, a_cmd, 32'h0000_0001);
    rdchk(a_ctrl, 32'h0000_037F);
    rdchk(a_stat, 32'h0000_0000);
    chk(32'(error_n_out), 32'h0000_0001);
    apb(1'b1, a_ctrl, 32'h0000_137F);
    rdchk(a_ctrl, 32'h0000_137F);
    apb(1'b1, a_cmd, 32'h0000_0001);
    rdchk(a_ctrl, 32'h0000_037F);
    apb(1'b1, a_cmd, 32'h0000_0002);
    rdchk(a_stat, 32'h0000_0000);
  endtask

  task automatic t_unmasked;
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, a_cmd, 32'h0000_0004);
      apb(1'b1, a_ctrl, 32'h0000_037F & ~(32'h0000_0001 << i));
      op(FXU_OP_ARITH, 6'h01 << i, 5'h00);
      rdchk(a_stat, 32'h0000_0080 | (32'h0000_0001 << i));
      chk(32'(error_n_out), 32'h0000_0000);
      rdchk(`FXU_ADDR_IPTR, op_iaddr);
      rdchk(`FXU_ADDR_DPTR, op_daddr);
      apb(1'b1, a_ctrl, 32'h0000_037F);
      apb(1'b1, a_cmd, 32'h0000_0004);
      op(FXU_OP_ARITH, 6'h01 << i, 5'h00);
      rdchk(a_stat, 32'h0000_0001 << i);
      chk(32'(error_n_out), 32'h0000_0001);
    end
  endtask

  task automatic t_masked;
    act(FXU_OP_ARITH, 6'h05, 5'h00, FXU_RES_QNAN, 8'h05);
    act(FXU_OP_ARITH, 6'h0C, 5'h00, FXU_RES_INF, 8'h0C);
    act(FXU_OP_ARITH, 6'h08, 5'h00, FXU_RES_INF, 8'h08);
    act(FXU_OP_ARITH, 6'h30, 5'h00, FXU_RES_DENZERO, 8'h30);
    act(FXU_OP_ARITH, 6'h02, 5'h00, FXU_RES_NORMAL, 8'h02);
    chk(32'(rk[1]), 32'h0000_0001);
    act(FXU_OP_ARITH, 6'h20, 5'h00, FXU_RES_NORMAL, 8'h20);
    act(FXU_OP_ARITH, 6'h01, 5'h10, FXU_RES_QNAN, 8'h41);
    act(FXU_OP_EXTRACT, 6'h00, 5'h02, FXU_RES_NEGINF_ST1, 8'h04);
    act(FXU_OP_SCALE, 6'h00, 5'h02, FXU_RES_QNAN, 8'h01);
    act(FXU_OP_SCALE, 6'h00, 5'h01, FXU_RES_ZERO, 8'h00);
    chk(32'(rk[0]), 32'h0000_0001);
    act(FXU_OP_SCALE, 6'h00, 5'h00, FXU_RES_INF, 8'h00);
    chk(32'(rk[0]), 32'h0000_0001);
    act(FXU_OP_ARITH, 6'h00, 5'h04, FXU_RES_NORMAL, 8'h00);
    act(FXU_OP_ARITH, 6'h00, 5'h08, FXU_RES_QNAN, 8'h01);
    act(FXU_OP_CMP_STORE, 6'h00, 5'h04, FXU_RES_QNAN, 8'h01);
    act(FXU_OP_LOAD_SD, 6'h02, 5'h00, FXU_RES_NORMAL, 8'h02);
    act(FXU_OP_LOAD_EXT, 6'h02, 5'h00, FXU_RES_NORMAL, 8'h00);
    act(FXU_OP_LOAD_SD, 6'h00, 5'h08, FXU_RES_QNAN, 8'h01);
    act(FXU_OP_TAN, 6'h01, 5'h10, FXU_RES_QNAN, 8'h41);
    act(FXU_OP_TAN, 6'h00, 5'h00, FXU_RES_NORMAL, 8'h00);
    apb(1'b1, a_ctrl, 32'h0000_077F);
    act(FXU_OP_ARITH, 6'h08, 5'h00, FXU_RES_MAXFIN, 8'h08);
    apb(1'b1, a_ctrl, 32'h0000_0F7F);
    act(FXU_OP_ARITH, 6'h08, 5'h00, FXU_RES_MAXFIN, 8'h08);
  endtask

  task automatic t_pins;
    apb(1'b1, a_ctrl, 32'h0000_037E);
    op(FXU_OP_ARITH, 6'h01, 5'h00);
    coprocessor_escape;
    chk(32'(trap16), 32'h0000_0000);
    status_enable <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(32'({error_n_oe_n, data_oe_n}), 32'h0000_0001);
    coprocessor_escape;
    chk(32'(trap16), 32'h0000_0001);
    bus_read <= 1'b1;
    coproc_select_low_n <= 1'b0;
    coproc_select_high <= 1'b1;
    bus_rdata <= 32'hA5C3_5A3C;
    repeat (2) @(posedge pclk);
    chk(32'(data_oe_n), 32'h0000_0000);
    chk(data_out, 32'hA5C3_5A3C);
    coproc_select_high <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(32'(data_oe_n), 32'h0000_0001);
    apb(1'b1, a_cmd, 32'h0000_0001);
    coprocessor_escape;
    chk(32'(trap16), 32'h0000_0000);
    status_enable <= 1'b0;
    bus_read <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(32'({error_n_oe_n, data_oe_n}), 32'h0000_0003);
  endtask

  initial
  begin
    miscompares = 0;
    tests_run = 0;
    {presetn, psel, penable, pwrite, op_valid, op_stack_fault, op_snan, op_qnan} = '0;
    {op_zero_src, op_scale_neg, status_enable, coproc_select_high, bus_read, esc_req} = '0;
    {paddr, pwdata, op_cond, bus_rdata} = '0;
    coproc_select_low_n = 1'b1;
    op_has_mem = 1'b1;
    pstrb = 4'hF;
    op_kind = FXU_OP_ARITH;
    op_iaddr = 32'h0000_4000;
    op_daddr = 32'h0008_0000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_init;
    t_unmasked;
    t_masked;
    t_pins;
    wrap_up;
  end

  initial
  begin
    #200_000;
    miscompares++;
    wrap_up;
  end
endmodule
`default_nettype wire
